// [tcc_core.sv]
// Design decisions made here: the address map and register access over APB.
`include "tcc_regs.svh"
module tcc_core
  import tcc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        event_in,
  output logic      [2:0]  wave_out_pin,
  output logic      [2:0]  wave_override
);

  ////////////////////////////////////////////////////////////////////////
  logic        enable_ff, nxt_enable;
  logic [2:0]  tick_source_select_ff, nxt_tick_source_select;
  logic [2:0]  waveform_select_ff, nxt_waveform_select;
  logic [2:0]  channel_output_enable_ff, nxt_channel_output_enable;
  logic        dir_down_ff, nxt_dir_down;
  logic        hold_updates_ff, nxt_hold_updates;
  logic        event_count_enable_ff, nxt_event_count_enable;
  logic [15:0] count_value_ff, nxt_count_value;
  logic [15:0] cycle_length_ff, nxt_cycle_length;
  logic [15:0] cycle_length_staging_ff, nxt_cycle_length_staging;
  logic        cycle_staging_valid_ff, nxt_cycle_staging_valid;
  logic [15:0] match_value_ff [3];
  logic [15:0] nxt_match_value [3];
  logic [15:0] match_staging_ff [3];
  logic [15:0] nxt_match_staging [3];
  logic [2:0]  match_staging_valid_ff, nxt_match_staging_valid;
  logic [2:0]  match_flag_ff, nxt_match_flag;
  logic        ceil_flag_ff, nxt_ceil_flag;
  logic [2:0]  wave_ff, nxt_wave;
  logic [9:0]  prescale_ff, nxt_prescale;
  logic [31:0] prdata_ff, nxt_prdata;
  logic        pready_ff, nxt_pready;
  logic        pslverr_ff, nxt_pslverr;

  ////////////////////////////////////////////////////////////////////////
  // no div 32 or 128: codes 5 to 7 step to 64, 256 and 1024
  function automatic logic [9:0] tcc_div_mask(input logic [2:0] sel);
    case (sel)
      3'h0:    tcc_div_mask = 10'h000;
      3'h1:    tcc_div_mask = 10'h001;
      3'h2:    tcc_div_mask = 10'h003;
      3'h3:    tcc_div_mask = 10'h007;
      3'h4:    tcc_div_mask = 10'h00F;
      3'h5:    tcc_div_mask = 10'h03F;
      3'h6:    tcc_div_mask = 10'h0FF;
      default: tcc_div_mask = 10'h3FF;
    endcase
  endfunction

  // word index of a match live or staging register, 3 when none
  function automatic logic [1:0] tcc_chan(input logic [11:0] a, input logic [11:0] base);
    logic [11:0] d;
    d = a - base;
    if (a >= base && d < 12'h00C && d[1:0] == 2'b00) begin
      tcc_chan = d[3:2];
    end else begin
      tcc_chan = 2'd3;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  logic        wr_access, rd_access, tick, at_floor, at_ceil, upd;
  logic        freq_mode, upd_at_floor;
  logic        access_wait, end_hit;
  logic [15:0] ceiling;
  logic [1:0]  wr_live_ch, wr_stg_ch, rd_live_ch, rd_stg_ch;
  logic [2:0]  match_now;

  // a write lands on the edge that shows pready high, as the master expects
  assign access_wait  = psel & penable & ~pready_ff;
  assign wr_access    = psel & penable & pwrite & pready_ff;
  // read data taken in the wait state, so it is fresh while pready stands
  assign rd_access    = access_wait & ~pwrite;
  assign freq_mode    = waveform_select_ff == TCC_WAVE_FREQ;
  assign ceiling      = freq_mode ? match_value_ff[0] : cycle_length_ff;
  assign at_floor     = count_value_ff == `TCC_FLOOR_VAL;
  assign at_ceil      = count_value_ff == ceiling;
  // dual slope and down counting update at the floor, the rest at the ceiling
  assign upd_at_floor = waveform_select_ff == TCC_WAVE_DS || dir_down_ff;
  // event pulses are taken as synchronous to pclk, one step per high cycle
  assign tick = enable_ff & (event_count_enable_ff ? event_in
              : (prescale_ff & tcc_div_mask(tick_source_select_ff)) == 10'h000);
  assign upd = tick & ~hold_updates_ff & (upd_at_floor ? at_floor : at_ceil);
  assign end_hit      = dir_down_ff ? at_floor : at_ceil;
  assign wr_live_ch = tcc_chan(paddr, `TCC_MATCH0);
  assign wr_stg_ch  = tcc_chan(paddr, `TCC_STG0);
  assign rd_live_ch = wr_live_ch;
  assign rd_stg_ch  = wr_stg_ch;

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      match_now[i] = count_value_ff == match_value_ff[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // counter, prescaler and control
  always_comb begin
    nxt_enable                = enable_ff;
    nxt_tick_source_select    = tick_source_select_ff;
    nxt_waveform_select       = waveform_select_ff;
    nxt_channel_output_enable = channel_output_enable_ff;
    nxt_dir_down              = dir_down_ff;
    nxt_hold_updates          = hold_updates_ff;
    nxt_event_count_enable    = event_count_enable_ff;
    nxt_count_value           = count_value_ff;
    // prescaler restarts on enable, so the first tick comes at once
    nxt_prescale              = enable_ff ? prescale_ff + 10'h001 : 10'h000;
    if (tick) begin
      // the up step wraps at all ones by itself, so a lowered ceiling waits
      if (!dir_down_ff) begin
        nxt_count_value = at_ceil ? `TCC_ZERO16 : count_value_ff + 16'h0001;
      end else begin
        nxt_count_value = at_floor ? ceiling : count_value_ff - 16'h0001;
      end
    end
    if (wr_access) begin
      case (paddr)
        `TCC_CTRL_A: begin
          nxt_enable             = pwdata[`TCC_A_ENABLE];
          nxt_tick_source_select = pwdata[`TCC_A_TICK_SOURCE_SELECT_LO +: 3];
        end
        `TCC_CTRL_B: begin
          nxt_waveform_select       = pwdata[`TCC_B_WAVE_LO +: 3];
          nxt_channel_output_enable = pwdata[`TCC_B_OE_LO +: 3];
        end
        `TCC_CTRL_E: begin
          nxt_dir_down     = pwdata[`TCC_E_DIR];
          nxt_hold_updates = pwdata[`TCC_E_HOLD];
        end
        `TCC_EVENT_CONTROL_REG: nxt_event_count_enable = pwdata[0];
        `TCC_COUNT:  nxt_count_value = pwdata[15:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_ff                <= 1'b0;
      tick_source_select_ff    <= 3'h0;
      waveform_select_ff       <= TCC_WAVE_NORMAL;
      channel_output_enable_ff <= 3'h0;
      dir_down_ff              <= 1'b0;
      hold_updates_ff          <= 1'b0;
      event_count_enable_ff    <= 1'b0;
      count_value_ff           <= `TCC_ZERO16;
      prescale_ff              <= 10'h000;
    end else begin
      enable_ff                <= nxt_enable;
      tick_source_select_ff    <= nxt_tick_source_select;
      waveform_select_ff       <= nxt_waveform_select;
      channel_output_enable_ff <= nxt_channel_output_enable;
      dir_down_ff              <= nxt_dir_down;
      hold_updates_ff          <= nxt_hold_updates;
      event_count_enable_ff    <= nxt_event_count_enable;
      count_value_ff           <= nxt_count_value;
      prescale_ff              <= nxt_prescale;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // live and staged values; a staging write beats a same-cycle update clear
  always_comb begin
    nxt_cycle_length         = cycle_length_ff;
    nxt_cycle_length_staging = cycle_length_staging_ff;
    nxt_cycle_staging_valid  = cycle_staging_valid_ff;
    nxt_match_staging_valid  = match_staging_valid_ff;
    for (int i = 0; i < 3; i++) begin
      nxt_match_value[i]   = match_value_ff[i];
      nxt_match_staging[i] = match_staging_ff[i];
    end
    // hold updates leaves staged values and their valid flags waiting
    if (upd) begin
      if (cycle_staging_valid_ff) begin
        nxt_cycle_length        = cycle_length_staging_ff;
        nxt_cycle_staging_valid = 1'b0;
      end
      for (int i = 0; i < 3; i++) begin
        if (match_staging_valid_ff[i]) begin
          nxt_match_value[i]         = match_staging_ff[i];
          nxt_match_staging_valid[i] = 1'b0;
        end
      end
    end
    if (wr_access) begin
      // a live write in an update cycle wins, being applied last
      if (paddr == `TCC_CYCLE) begin
        nxt_cycle_length = pwdata[15:0];
      end
      if (paddr == `TCC_CYCLE_STG) begin
        nxt_cycle_length_staging = pwdata[15:0];
        nxt_cycle_staging_valid  = 1'b1;
      end
      if (wr_live_ch != 2'd3) begin
        nxt_match_value[wr_live_ch] = pwdata[15:0];
      end
      if (wr_stg_ch != 2'd3) begin
        nxt_match_staging[wr_stg_ch]       = pwdata[15:0];
        nxt_match_staging_valid[wr_stg_ch] = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cycle_length_ff         <= `TCC_CYCLE_RST;
      cycle_length_staging_ff <= `TCC_ZERO16;
      cycle_staging_valid_ff  <= 1'b0;
      match_staging_valid_ff  <= 3'h0;
      for (int i = 0; i < 3; i++) begin
        match_value_ff[i]   <= `TCC_ZERO16;
        match_staging_ff[i] <= `TCC_ZERO16;
      end
    end else begin
      cycle_length_ff         <= nxt_cycle_length;
      cycle_length_staging_ff <= nxt_cycle_length_staging;
      cycle_staging_valid_ff  <= nxt_cycle_staging_valid;
      match_staging_valid_ff  <= nxt_match_staging_valid;
      for (int i = 0; i < 3; i++) begin
        match_value_ff[i]   <= nxt_match_value[i];
        match_staging_ff[i] <= nxt_match_staging[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // flags and toggles land on the tick that ends the matching count,
  // one timer clock after the count got there; a set beats a clear
  always_comb begin
    nxt_match_flag = match_flag_ff;
    nxt_ceil_flag  = ceil_flag_ff;
    nxt_wave       = wave_ff;
    if (wr_access && paddr == `TCC_FLAGS) begin
      nxt_match_flag = match_flag_ff & ~pwdata[2:0];
      nxt_ceil_flag  = ceil_flag_ff & ~pwdata[`TCC_FLAG_CEIL];
    end
    if (tick) begin
      if (end_hit) begin
        nxt_ceil_flag = 1'b1;
      end
      for (int i = 0; i < 3; i++) begin
        if (match_now[i]) begin
          nxt_match_flag[i] = 1'b1;
          if (freq_mode) begin
            nxt_wave[i] = ~wave_ff[i];
          end
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_flag_ff <= 3'h0;
      ceil_flag_ff  <= 1'b0;
      wave_ff       <= 3'h0;
    end else begin
      match_flag_ff <= nxt_match_flag;
      ceil_flag_ff  <= nxt_ceil_flag;
      wave_ff       <= nxt_wave;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, reads above 0x03C or misaligned read zero with pslverr
  always_comb begin
    nxt_pready  = access_wait;
    nxt_pslverr = 1'b0;
    nxt_prdata  = prdata_ff;
    if (rd_access) begin
      nxt_prdata = 32'h0000_0000;
      case (paddr)
        `TCC_CTRL_A:    nxt_prdata[3:0] = {tick_source_select_ff, enable_ff};
        `TCC_CTRL_B:    nxt_prdata[6:0] = {channel_output_enable_ff, 1'b0, waveform_select_ff};
        `TCC_CTRL_E:    nxt_prdata[1:0] = {hold_updates_ff, dir_down_ff};
        `TCC_CTRL_F:    nxt_prdata[3:0] = {cycle_staging_valid_ff, match_staging_valid_ff};
        `TCC_EVENT_CONTROL_REG:    nxt_prdata[0]   = event_count_enable_ff;
        `TCC_FLAGS:     nxt_prdata[3:0] = {ceil_flag_ff, match_flag_ff};
        `TCC_COUNT:     nxt_prdata[15:0] = count_value_ff;
        `TCC_CYCLE:     nxt_prdata[15:0] = cycle_length_ff;
        `TCC_CYCLE_STG: nxt_prdata[15:0] = cycle_length_staging_ff;
        default: begin
          if (rd_live_ch != 2'd3) begin
            nxt_prdata[15:0] = match_value_ff[rd_live_ch];
          end else if (rd_stg_ch != 2'd3) begin
            nxt_prdata[15:0] = match_staging_ff[rd_stg_ch];
          end
        end
      endcase
    end
    // 0x30 sits in a gap: it reads zero and raises no error
    if (access_wait) begin
      nxt_pslverr = paddr > 12'h03C || paddr[1:0] != 2'b00;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      prdata_ff  <= nxt_prdata;
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // pin override registered so the outputs leave flip-flops directly
  logic [2:0] override_ff;
  logic [2:0] pin_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      override_ff <= 3'h0;
      pin_ff      <= 3'h0;
    end else begin
      // unlisted wave codes still count as a waveform mode
      override_ff <= (waveform_select_ff != TCC_WAVE_NORMAL) ? channel_output_enable_ff
                   : 3'h0;
      pin_ff      <= wave_ff;
    end
  end

  assign prdata        = prdata_ff;
  assign pready        = pready_ff;
  assign pslverr       = pslverr_ff;
  assign wave_out_pin  = pin_ff;
  assign wave_override = override_ff;

endmodule

// [tcc_regs.svh]
`ifndef TCC_REGS_SVH
`define TCC_REGS_SVH

// register byte offsets
`define TCC_CTRL_A      12'h000
`define TCC_CTRL_B      12'h004
`define TCC_CTRL_E      12'h008
`define TCC_CTRL_F      12'h00C
`define TCC_EVENT_CONTROL_REG      12'h010
`define TCC_FLAGS       12'h014
`define TCC_COUNT       12'h018
`define TCC_CYCLE       12'h01C
`define TCC_CYCLE_STG   12'h020
`define TCC_MATCH0      12'h024
`define TCC_STG0        12'h034
// field positions
`define TCC_A_ENABLE    0
`define TCC_A_TICK_SOURCE_SELECT_LO 1
`define TCC_B_WAVE_LO   0
`define TCC_B_OE_LO     4
`define TCC_E_DIR       0
`define TCC_E_HOLD      1
`define TCC_F_FLOOR     3
`define TCC_FLAG_CEIL   3
// reset values and the count floor
`define TCC_CYCLE_RST   16'hFFFF
`define TCC_ZERO16      16'h0000
`define TCC_FLOOR_VAL   16'h0000
`endif

// [tcc_pkg.sv]
package tcc_pkg;
  typedef enum logic [2:0] {
    TCC_WAVE_NORMAL = 3'b000,
    TCC_WAVE_FREQ   = 3'b001,
    TCC_WAVE_SS     = 3'b011,
    TCC_WAVE_DS     = 3'b101
  } tcc_wave_t;
endpackage

// [tcc_core_properties.sv]
`include "tcc_regs.svh"
module tcc_core_properties
  import tcc_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        event_in,
  input wire logic [2:0]  wave_out_pin,
  input wire logic [2:0]  wave_override
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  // shadow of the waveform control word
  logic [2:0] mode_ff, nxt_mode, oe_ff, nxt_oe;
  logic [1:0] age_ff, nxt_age;
  logic [2:0] exp_override;
  logic       steady_normal;
  assign exp_override  = (mode_ff != 3'h0) ? oe_ff : 3'h0;
  assign steady_normal = age_ff == 2'd3 && mode_ff != TCC_WAVE_FREQ;
  always_comb begin
    nxt_mode = mode_ff;
    nxt_oe   = oe_ff;
    nxt_age  = (age_ff == 2'd3) ? age_ff : age_ff + 2'd1;
    if (psel && penable && pready && pwrite && paddr == `TCC_CTRL_B) begin
      nxt_mode = pwdata[2:0];
      nxt_oe   = pwdata[6:4];
      nxt_age  = 2'd0;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff <= 3'h0;
      oe_ff   <= 3'h0;
      age_ff  <= 2'd0;
    end else begin
      mode_ff <= nxt_mode;
      oe_ff   <= nxt_oe;
      age_ff  <= nxt_age;
    end
  end
  ////////////////////////////////////////
  a_ready_one_wait: assert property ($rose(penable) && psel |=> pready)
    else $error("no ready one cycle after access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_ready_cause: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  a_err_unmapped: assert property (pready && paddr > 12'h03C |-> pslverr)
    else $error("unmapped access not refused");
  a_err_reads_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
    else $error("refused read not zero");
  a_upper_zero: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  a_override_mode: assert property (age_ff == 2'd3 |-> wave_override == exp_override)
    else $error("override does not follow mode and enable");
  a_wave_hold: assert property (steady_normal |=> $stable(wave_out_pin))
    else $error("waveform moved outside frequency mode");
  cover property (pready && pslverr);
  cover property ($changed(wave_out_pin));
  cover property (wave_override != 3'h0);
endmodule
bind tcc_core tcc_core_properties i_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .event_in(event_in), .wave_out_pin(wave_out_pin),
  .wave_override(wave_override));

// [tcc_pin_model.sv]
module tcc_pin_model (
  input  wire logic [2:0] wave_out_pin,
  input  wire logic [2:0] wave_override,
  input  wire logic [2:0] port_out,
  input  wire logic [2:0] port_dir,
  output logic      [2:0] pin_level
);
  timeunit 1ns;
  timeprecision 1ns;
  // input pins sit on a pull-up, so they read high
  assign pin_level = (port_dir & ((wave_override & wave_out_pin) | (~wave_override & port_out)))
                     | ~port_dir;
endmodule

// [tb.sv]
`include "tcc_regs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, event_in, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, rs;
  logic [2:0]  wave_out_pin, wave_override, pin_level;
  int          bad_count, n_compared, per, stg, cnt, hold, dn, en, stg_v;
  tcc_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .event_in(event_in), .wave_out_pin(wave_out_pin),
    .wave_override(wave_override));
  tcc_pin_model i_pins (.wave_out_pin(wave_out_pin), .wave_override(wave_override),
    .port_out(3'b000), .port_dir(3'b001), .pin_level(pin_level));
  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  ////////////////////////////////////////
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // holds the request until ready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      conclude();
    end
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wr(input logic [11:0] a, input int d);
    apb(1, a, 32'(d));
  endtask
  task automatic rd(input logic [11:0] a, input int x);
    apb(0, a, 32'h0000_0000);
    chk(q, 32'(x));
  endtask
  // one event pulse per step, model follows
  task automatic ev(input int k);
    repeat (k) begin
      @(posedge pclk);
      event_in <= 1;
      @(posedge pclk);
      event_in <= 0;
      if (en == 0) continue;
      if (dn != 0) cnt = (cnt == 0) ? per : cnt - 1;
      else if (cnt == per) begin
        cnt = 0;
        if (stg_v != 0 && hold == 0) begin
          per = stg;
          stg_v = 0;
        end
      end else cnt = (cnt + 1) & 32'h0000_FFFF;
    end
    repeat (2) @(posedge pclk);
  endtask
  task automatic conclude;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #200_000;
    bad_count++;
    conclude();
  end
  ////////////////////////////////////////
  initial begin
    rs = 52;
    {psel, penable, pwrite, event_in, presetn} = 5'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    {hold, dn, en, stg_v} = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1;
    rd(`TCC_CYCLE, 32'h0000_FFFF);
    rd(`TCC_COUNT, 0);
    apb(0, 12'h040, 32'h0000_0000);
    chk({31'h0, e}, 1);
    $display("test reset done");
    per = 5;
    wr(`TCC_CYCLE, per);
    wr(`TCC_EVENT_CONTROL_REG, 1);
    wr(`TCC_CTRL_A, 1);
    en = 1;
    cnt = 3;
    wr(`TCC_COUNT, cnt);
    ev(int'(rnd() % 13));
    rd(`TCC_COUNT, cnt);
    cnt = 32'h0000_FFFE;
    wr(`TCC_COUNT, cnt);
    ev(3);
    rd(`TCC_COUNT, cnt);
    wr(`TCC_CTRL_A, 0);
    en = 0;
    ev(4);
    rd(`TCC_COUNT, cnt);
    wr(`TCC_CTRL_A, 1);
    en = 1;
    dn = 1;
    wr(`TCC_CTRL_E, 1);
    cnt = int'(rnd() % 5);
    wr(`TCC_COUNT, cnt);
    ev(int'(rnd() % 11));
    rd(`TCC_COUNT, cnt);
    $display("test counting done");
    dn = 0;
    wr(`TCC_CTRL_E, 0);
    cnt = per;
    wr(`TCC_COUNT, cnt);
    stg = 9;
    stg_v = 1;
    wr(`TCC_CYCLE_STG, stg);
    rd(`TCC_CTRL_F, 32'h0000_0008);
    rd(`TCC_CYCLE, per);
    ev(1);
    rd(`TCC_CTRL_F, 0);
    rd(`TCC_CYCLE, per);
    $display("test staging done");
    wr(`TCC_MATCH0, 2);
    cnt = 0;
    wr(`TCC_COUNT, cnt);
    wr(`TCC_FLAGS, 32'h0000_000F);
    ev(2);
    apb(0, `TCC_FLAGS, 32'h0000_0000);
    chk(q & 32'h1, 0);
    ev(1);
    apb(0, `TCC_FLAGS, 32'h0000_0000);
    chk(q & 32'h1, 1);
    $display("test match done");
    wr(`TCC_CTRL_B, 32'h0000_0011);
    per = 2;
    cnt = 0;
    wr(`TCC_COUNT, cnt);
    ev(5);
    rd(`TCC_COUNT, cnt);
    chk({29'h0, wave_override}, 1);
    chk({31'h0, wave_out_pin[0]}, 1);
    chk({31'h0, pin_level[0]}, 1);
    wr(`TCC_CTRL_B, 32'h0000_0070);
    repeat (3) @(posedge pclk);
    chk({29'h0, wave_override}, 0);
    $display("test waveform done");
    per = 9;
    hold = 1;
    wr(`TCC_CTRL_E, 2);
    cnt = per;
    wr(`TCC_COUNT, cnt);
    stg = 4;
    stg_v = 1;
    wr(`TCC_CYCLE_STG, stg);
    ev(1);
    rd(`TCC_CTRL_F, 32'h0000_0008);
    rd(`TCC_CYCLE, per);
    $display("test hold done");
    conclude();
  end
endmodule
